// File: hdl/tasp_pkg.sv
package tasp_pkg;
	// clock figures
	localparam int         CLK_NS      = 20;   // mclk period
	localparam int         BCLK_NS     = 160;  // driven bit clock period
	localparam int         BCLK_HALF   = BCLK_NS / CLK_NS / 2;
	localparam logic [3:0] BCLK_HALF_C = 4'(BCLK_HALF - 1);
	// channel count of this host port
	localparam int         NCH         = 2;
	// register byte offsets
	localparam logic [4:0] A_CTRL      = 5'h00;
	localparam logic [4:0] A_FRAME     = 5'h04;
	localparam logic [4:0] A_SLOT      = 5'h08;
	localparam logic [4:0] A_TX0       = 5'h0C;
	localparam logic [4:0] A_TX1       = 5'h10;
	localparam logic [4:0] A_RX0       = 5'h14;
	localparam logic [4:0] A_RX1       = 5'h18;
	localparam logic [4:0] A_STAT      = 5'h1C;
	// control fields
	localparam int         C_EN        = 0;
	localparam int         C_MST       = 1;
	localparam int         C_FMT       = 2;
	localparam int         C_TRI       = 4;
	localparam int         C_TXE       = 5;
	localparam int         C_RXE       = 7;
	// frame fields
	localparam int         F_FL        = 0;
	localparam int         F_SL        = 16;
	localparam int         F_WL        = 24;
	// slot fields, four bits per channel
	localparam int         S_TX        = 0;
	localparam int         S_RX        = 8;
	// reset values
	localparam logic [31:0] CTRL_RST   = 32'h00000000;
	localparam logic [31:0] FRAME_RST  = 32'h18200040;
	localparam logic [31:0] SLOT_RST   = 32'h00001010;
	// long word handling
	localparam logic [5:0] WORD_32     = 6'h20;
	localparam int         LSB_IGN     = 8;
	// framing formats, gray along the list
	typedef enum logic [1:0] {
		FMT_DSPA = 2'h0,
		FMT_DSPB = 2'h1,
		FMT_LJ   = 2'h3,
		FMT_I2S  = 2'h2
	} tasp_fmt_t;
endpackage

// File: hdl/tasp_host.sv
// What this block does
// RQ1 - device ports: eight or two channels
// RQ2 - tx and rx paths configured apart
// RQ3 - clock master drives both clocks
// RQ4 - four formats: DSP-A, DSP-B, I2S, LJ
// RQ5 - LJ and DSP-B need device master
// RQ6 - words shift MSB first
// RQ7 - samples are signed two's complement
// RQ8 - single pair uses first slot
// RQ9 - device may invert clock polarities; this host has no polarity setting, data change on fall and are sampled on rise
// RQ10 - DSP MSB: edge one (B), two (A)
// RQ11 - right word follows left, no gap
// RQ12 - frame pulse short, falls early enough
// RQ13 - mono travels as left channel
// RQ14 - I2S MSB on second edge after change
// RQ15 - LJ MSB on first edge after change
// RQ16 - one sample rate per port
// RQ17 - per-channel enables, one slot each
// RQ18 - DSP slots consecutive; split even/odd halves
// RQ19 - slots distinct per channel, gaps allowed
// RQ20 - slot, word and frame lengths configurable
// RQ21 - device output may tristate idle slots
// RQ22 - 32-bit words: low eight bits ignored
// RQ23 - master clocks run while channel enabled
// RQ24 - device may advance frame clock edge; this host has no setting for it, slave resync uses fixed positions
// RQ25 - data changes on fall, sampled rise
// RQ26 - master counts frame length for frame clock
module tasp_host (
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	input  wire logic [4:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_we,
	input  wire logic                 reg_re,
	output logic      [31:0]          reg_rdata,
	input  wire logic                 bclk_i,
	output logic                      bclk_o,
	output logic                      bclk_oe,
	input  wire logic                 fclk_i,
	output logic                      fclk_o,
	output logic                      fclk_oe,
	input  wire logic                 serial_out_pin,
	output logic                      serial_in_pin_o,
	output logic                      serial_in_pin_oe
);
	import tasp_pkg::*;

	// register file
	logic [31:0]          ctrl_q, ctrl_d;   // control
	logic [31:0]          frame_q, frame_d; // lengths
	logic [31:0]          slot_q, slot_d;   // slot numbers
	logic [NCH-1:0][31:0] txr_q, txr_d;     // words from software
	logic [NCH-1:0][31:0] txc_q, txc_d;     // words of this frame
	wire  [NCH-1:0][31:0] rxw;              // received words
	wire  [NCH-1:0]       done;             // word complete
	logic                 rxn_q, rxn_d;     // new word sticky
	logic                 txn_q, txn_d;     // words taken sticky
	logic [31:0]          rd_d;             // read data next
	logic                 load;             // frame start load

	// field decode
	tasp_fmt_t   fmt;
	assign fmt = tasp_fmt_t'(ctrl_q[C_FMT+:2]);
	wire         en    = ctrl_q[C_EN];
	wire         mst   = ctrl_q[C_MST];
	wire  [9:0]  fl    = frame_q[F_FL+:10];
	wire  [5:0]  sl    = frame_q[F_SL+:6];
	wire  [5:0]  wl    = frame_q[F_WL+:6];
	wire  [9:0]  half  = {1'b0, fl[9:1]};
	wire         split = (fmt == FMT_I2S) || (fmt == FMT_LJ);
	wire         one   = (fmt == FMT_DSPA) || (fmt == FMT_I2S);
	wire  [9:0]  off   = {9'h000, one};
	// host as clock master: only formats the slave device accepts
	wire         bad   = mst && ((fmt == FMT_DSPB) || (fmt == FMT_LJ)); // RQ5
	wire         run   = en && !bad;

	// pin synchronisers, two flops before any use
	logic [2:0]  bsy_q;  // bit clock, bit 2 for edges
	logic [1:0]  fsy_q;  // frame clock
	logic [1:0]  dsy_q;  // device data out
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bsy_q <= 3'h0;
			fsy_q <= 2'h0;
			dsy_q <= 2'h0;
		end else begin
			bsy_q <= {bsy_q[1:0], bclk_i};
			fsy_q <= {fsy_q[0], fclk_i};
			dsy_q <= {dsy_q[0], serial_out_pin};
		end
	end

	// bit clock divider, master only
	logic [3:0]  div_q, div_d;
	logic        bck_d;
	always_comb begin
		div_d = 4'h0;
		bck_d = 1'b0;
		// stopped unless the port runs: enabled with a legal format, channel enables aside
		if (run && mst) begin // RQ23
			if (div_q == BCLK_HALF_C) begin
				bck_d = ~bclk_o; // RQ3
			end else begin
				div_d = div_q + 4'h1;
				bck_d = bclk_o;
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_q   <= 4'h0;
			bclk_o  <= 1'b0;
			bclk_oe <= 1'b0;
		end else begin
			div_q   <= div_d;
			bclk_o  <= bck_d;
			bclk_oe <= run && mst; // RQ3
		end
	end

	// bit clock edge events, own or sampled
	wire tick = run && mst && (div_q == BCLK_HALF_C);
	wire rise = mst ? (tick && !bclk_o) : (run && bsy_q[1] && !bsy_q[2]);
	wire fall = mst ? (tick && bclk_o) : (run && !bsy_q[1] && bsy_q[2]);

	// frame position state: describes the coming rising edge
	logic [9:0]  pos_q, pos_d, np;  // bit position in frame
	logic [5:0]  bis_q, bis_d;      // bit within slot
	logic [3:0]  sn_q, sn_d, snx;   // slot number
	logic        act_q, act_d;      // inside a slot
	logic        fpv_q, fpv_d;      // last sampled frame clock
	logic        fo_d, so_d, soe_d; // pin next values
	wire  [NCH-1:0] thit, tbit, rhit;

	// per channel slot match and serial shifting
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [31:0] sh_q, sh_d;  // rx shift
		logic [31:0] rw_q, rw_d;  // rx word
		// channel owns the current slot bit
		assign thit[c] = act_q && ctrl_q[C_TXE+c] && (bis_q < wl)
			&& (sn_q == {1'b0, slot_q[S_TX+4*c+:3]}); // RQ17 RQ2
		assign rhit[c] = act_q && ctrl_q[C_RXE+c] && (bis_q < wl)
			&& (sn_q == {1'b0, slot_q[S_RX+4*c+:3]}); // RQ17 RQ2
		// MSB goes out first
		assign tbit[c] = txc_q[c][5'(wl - 6'h1 - bis_q)]; // RQ6
		assign done[c] = rise && rhit[c] && (bis_q == wl - 6'h1);
		assign rxw[c]  = rw_q;
		always_comb begin
			sh_d = sh_q;
			rw_d = rw_q;
			// sample on rising edges
			if (rise && rhit[c]) begin // RQ25
				if (bis_q == 6'h00) begin
					sh_d = {31'h00000000, dsy_q[1]};
				end else begin
					sh_d = {sh_q[30:0], dsy_q[1]}; // RQ6
				end
				// word right aligned, sign at wl-1
				if (bis_q == wl - 6'h1) begin // RQ7
					rw_d = sh_d;
					if (wl == WORD_32) begin
						rw_d[LSB_IGN-1:0] = '0; // RQ22
					end
				end
			end
		end
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				sh_q <= 32'h00000000;
				rw_q <= 32'h00000000;
			end else begin
				sh_q <= sh_d;
				rw_q <= rw_d;
			end
		end
	end

	// frame sequencing and pin drive
	always_comb begin
		pos_d  = pos_q;
		bis_d  = bis_q;
		sn_d   = sn_q;
		act_d  = act_q;
		fpv_d  = fpv_q;
		fo_d   = fclk_o;
		so_d   = serial_in_pin_o;
		soe_d  = serial_in_pin_oe;
		txc_d  = txc_q;
		load   = 1'b0;
		np     = 10'h000;
		snx    = sn_q + (split ? 4'h2 : 4'h1);
		if (!run) begin
			// idle: first edge lands on last position
			pos_d = fl - 10'h1;
			act_d = 1'b0;
			fo_d  = 1'b0;
			so_d  = 1'b0;
			soe_d = 1'b0;
		end else if (rise) begin
			// count to frame length and wrap
			np    = (pos_q >= fl - 10'h1) ? 10'h000 : pos_q + 10'h1; // RQ20 RQ26
			fpv_d = fsy_q[1];
			// host as slave: realign on the device frame edges
			if (!mst && (fsy_q[1] != fpv_q)) begin
				if (!split && fsy_q[1]) begin
					np = 10'h001; // RQ10
				end else if (split && (fsy_q[1] == (fmt == FMT_LJ))) begin
					np = 10'h001; // RQ14 RQ15
				end else if (split) begin
					np = half + 10'h1; // RQ14 RQ15
				end
			end
			pos_d = np; // RQ16
			if (np == off) begin
				// first slot after the offset
				act_d = 1'b1; // RQ8 RQ10 RQ14 RQ15
				sn_d  = 4'h0;
				bis_d = 6'h00;
			end else if (split && (np == half + off)) begin
				// odd slots start the second half
				act_d = 1'b1; // RQ18
				sn_d  = 4'h1;
				bis_d = 6'h00;
			end else if ((np == 10'h000) || (split && (np == half))) begin
				act_d = 1'b0;
			end else if (bis_q == sl - 6'h1) begin
				// next slot follows with no gap
				bis_d = 6'h00; // RQ11 RQ18
				sn_d  = snx;
				if (snx[3]) begin
					act_d = 1'b0;
				end
			end else begin
				bis_d = bis_q + 6'h01;
			end
			// capture software words at frame start
			if (np == 10'h000) begin
				txc_d = txr_q;
				load  = 1'b1;
			end
		end else if (fall) begin
			// change outputs on falling edges
			fo_d  = (fmt == FMT_I2S) ? (pos_q >= half)
				: (pos_q == 10'h000); // RQ10 RQ12 RQ14 RQ26
			// distinct slots keep one channel per bit
			so_d  = |(thit & tbit); // RQ25 RQ19 RQ13
			soe_d = (|thit) || !ctrl_q[C_TRI];
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pos_q            <= 10'h000;
			bis_q            <= 6'h00;
			sn_q             <= 4'h0;
			act_q            <= 1'b0;
			fpv_q            <= 1'b0;
			txc_q            <= '0;
			fclk_o           <= 1'b0;
			fclk_oe          <= 1'b0;
			serial_in_pin_o  <= 1'b0;
			serial_in_pin_oe <= 1'b0;
		end else begin
			pos_q            <= pos_d;
			bis_q            <= bis_d;
			sn_q             <= sn_d;
			act_q            <= act_d;
			fpv_q            <= fpv_d;
			txc_q            <= txc_d;
			fclk_o           <= fo_d;
			fclk_oe          <= run && mst; // RQ3
			serial_in_pin_o  <= so_d;
			serial_in_pin_oe <= soe_d;
		end
	end

	// register access
	always_comb begin
		ctrl_d  = ctrl_q;
		frame_d = frame_q;
		slot_d  = slot_q;
		txr_d   = txr_q;
		rxn_d   = rxn_q;
		txn_d   = txn_q;
		rd_d    = 32'h00000000;
		if (reg_we) begin
			case (reg_addr)
				A_CTRL:  ctrl_d   = reg_wdata;
				A_FRAME: frame_d  = reg_wdata;
				A_SLOT:  slot_d   = reg_wdata;
				A_TX0:   txr_d[0] = reg_wdata;
				A_TX1:   txr_d[1] = reg_wdata;
				default: ;
			endcase
		end
		if (reg_re) begin
			case (reg_addr)
				A_CTRL:  rd_d = ctrl_q;
				A_FRAME: rd_d = frame_q;
				A_SLOT:  rd_d = slot_q;
				A_TX0:   rd_d = txr_q[0];
				A_TX1:   rd_d = txr_q[1];
				A_RX0:   rd_d = rxw[0];
				A_RX1:   rd_d = rxw[1];
				A_STAT: begin
					rd_d  = {29'h00000000, txn_q, rxn_q, run};
					rxn_d = 1'b0;
					txn_d = 1'b0;
				end
				default: rd_d = 32'h00000000;
			endcase
		end
		// events win over a clearing read
		if (|done) begin
			rxn_d = 1'b1;
		end
		if (load) begin
			txn_d = 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q    <= CTRL_RST;
			frame_q   <= FRAME_RST;
			slot_q    <= SLOT_RST;
			txr_q     <= '0;
			rxn_q     <= 1'b0;
			txn_q     <= 1'b0;
			reg_rdata <= 32'h00000000;
		end else begin
			ctrl_q    <= ctrl_d;
			frame_q   <= frame_d;
			slot_q    <= slot_d;
			txr_q     <= txr_d;
			rxn_q     <= rxn_d;
			txn_q     <= txn_d;
			reg_rdata <= rd_d;
		end
	end

	// channel 0 set on slot 0
	wire c0s0 = ctrl_q[C_TXE] && (slot_q[S_TX+:3] == 3'h0) && (wl != 6'h00);

	bclk_half_a: assert property ( // RQ3
		@(posedge mclk) disable iff (!rst_n)
		$rose(bclk_o) && run ##1 run[*3] |-> bclk_o ##1 !bclk_o)
		else $error("bit clock half period wrong");
	fpulse_len_a: assert property ( // RQ12
		@(posedge mclk) disable iff (!rst_n)
		$rose(fclk_o) ##0 (run && fmt == FMT_DSPA && fl > 10'h1)[*8]
		|-> ##1 !fclk_o)
		else $error("frame pulse not one bit long");
	dspa_msb_a: assert property ( // RQ10
		@(posedge mclk) disable iff (!rst_n)
		$rose(fclk_o) && run && fmt == FMT_DSPA && c0s0
		##1 (run && fmt == FMT_DSPA && c0s0)[*8]
		|-> serial_in_pin_o == txc_q[0][5'(wl - 6'h1)])
		else $error("DSP-A MSB not at second edge");
	// master only: a slave resync may put the frame edge on the MSB fall
	i2s_msb_a: assert property ( // RQ14
		@(posedge mclk) disable iff (!rst_n)
		$fell(fclk_o) && run && mst && fmt == FMT_I2S && c0s0
		##1 (run && mst && fmt == FMT_I2S && c0s0)[*8]
		|-> serial_in_pin_o == txc_q[0][5'(wl - 6'h1)])
		else $error("I2S MSB not at second edge");
	fmt_refuse_a: assert property ( // RQ5
		@(posedge mclk) disable iff (!rst_n)
		bad |=> !bclk_oe && !fclk_oe && !serial_in_pin_oe)
		else $error("illegal master format ran");
	slot_step_a: assert property ( // RQ11
		@(posedge mclk) disable iff (!rst_n)
		rise && act_q && !split && bis_q == sl - 6'h1 && mst
		&& pos_d != off && pos_d != 10'h000 && sn_q < 4'h7
		|=> sn_q == $past(sn_q) + 4'h1 && bis_q == 6'h00)
		else $error("slot gap after word");
	pos_range_a: assert property ( // RQ20
		@(posedge mclk) disable iff (!rst_n)
		run && $past(run) && $stable(frame_q) |-> pos_q < fl)
		else $error("position past frame length");
	rx_lsb_a: assert property ( // RQ22
		@(posedge mclk) disable iff (!rst_n)
		done[0] && wl == WORD_32 |=> rxw[0][LSB_IGN-1:0] == 8'h00)
		else $error("32-bit low byte kept");
endmodule // tasp_host

// File: verification/tasp_dev.sv
// behavioural codec port: frames on the wire bit clock
module tasp_dev (
	input  wire logic                bclk,
	input  wire logic                fclk,
	input  wire logic                din,
	input  wire logic                mst,
	input  wire tasp_pkg::tasp_fmt_t fmt,
	input  wire logic [9:0]          fl,
	input  wire logic [5:0]          sl,
	input  wire logic [5:0]          wl,
	input  wire logic [31:0]         tx0,
	input  wire logic [31:0]         tx1,
	output logic                     bclk_d,
	output logic                     fclk_d,
	output logic                     dout,
	output logic [31:0]              rx0,
	output logic [31:0]              rx1
);
	timeunit 1ns;
	timeprecision 1ns;
	import tasp_pkg::*;
	int          pos = 0;  // bit position in frame
	logic        pf = 0;   // frame clock at last rise
	logic [31:0] sh[2];    // receive shifters
	// outputs start quiet; bit clock parks low when not master
	initial begin
		{fclk_d, dout, rx0, rx1} = '0;
		bclk_d = 0;
		forever #(BCLK_NS / 2) bclk_d = mst ? ~bclk_d : 1'b0;
	end
	// first bit position of a channel
	function automatic int ofs(int c);
		int o;
		o = (fmt == FMT_DSPA || fmt == FMT_I2S) ? 1 : 0;
		if (fmt == FMT_DSPA || fmt == FMT_DSPB)
			return o + c * sl;
		return o + c * (fl / 2);
	endfunction
	// next bit and frame clock change on falling edge
	always @(negedge bclk) begin
		int np, k;
		logic b;
		np = (pos + 1) % fl;
		b = 0; // pull-down outside words
		for (int c = 0; c < 2; c++) begin
			k = np - ofs(c);
			if (k >= 0 && k < wl && !(wl == 32 && k >= 24))
				b = c ? tx1[wl - 1 - k] : tx0[wl - 1 - k];
		end
		dout <= b;
		if (mst)
			fclk_d <= (fmt == FMT_I2S) ? np >= fl / 2 :
				(fmt == FMT_LJ) ? np < fl / 2 : np == 0;
	end
	// resync on frame edge, sample on rising edge
	always @(posedge bclk) begin
		int k;
		if (fmt == FMT_I2S ? (pf && !fclk) : (!pf && fclk))
			pos = 0;
		else
			pos = (pos + 1) % fl;
		pf = fclk;
		for (int c = 0; c < 2; c++) begin
			k = pos - ofs(c);
			if (k >= 0 && k < wl)
				sh[c] = {sh[c][30:0], (wl == 32 && k >= 24) ? 1'b0 : din};
			if (k == wl - 1 && c == 0)
				rx0 = sh[0] & 32'((64'h1 << wl) - 1);
			if (k == wl - 1 && c == 1)
				rx1 = sh[1] & 32'((64'h1 << wl) - 1);
		end
	end
endmodule // tasp_dev

// File: verification/test_tasp_host.sv
module test_tasp_host;
	timeunit 1ns;
	timeprecision 1ns;
	import tasp_pkg::*;
	logic        mclk = 0;
	logic        rst_n = 0;
	logic [4:0]  reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic        reg_we = 0;
	logic        reg_re = 0;
	logic [31:0] reg_rdata;
	logic        bclk_o, bclk_oe, fclk_o, fclk_oe, sin_o, sin_oe;
	logic        dbclk, dfclk, dout, dev_mst = 0;
	tasp_fmt_t   fmt = FMT_DSPA;
	logic [9:0]  fl = 10'h050;      // frame fits two 32-bit words
	logic [5:0]  sl = 6'h20;
	logic [5:0]  wl = 6'h18;
	logic [31:0] dtx0 = 0, dtx1 = 0, drx0, drx1, htx0, htx1, rv;
	logic [5:0]  wls[3] = '{6'h10, 6'h18, 6'h20};
	int          bad_count = 0, n_checks = 0, cyc = 0;
	// wire levels from whoever drives; data line pulled down
	wire bclk_w = bclk_oe ? bclk_o : dev_mst & dbclk;
	wire fclk_w = fclk_oe ? fclk_o : dev_mst & dfclk;
	wire din_w  = sin_oe ? sin_o : 1'b0;
	tasp_host tasp_host_inst (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .bclk_i(bclk_w),
		.bclk_o(bclk_o), .bclk_oe(bclk_oe), .fclk_i(fclk_w),
		.fclk_o(fclk_o), .fclk_oe(fclk_oe), .serial_out_pin(dout),
		.serial_in_pin_o(sin_o), .serial_in_pin_oe(sin_oe));
	tasp_dev tasp_dev_inst (.bclk(bclk_w), .fclk(fclk_w), .din(din_w),
		.mst(dev_mst), .fmt(fmt), .fl(fl), .sl(sl), .wl(wl), .tx0(dtx0),
		.tx1(dtx1), .bclk_d(dbclk), .fclk_d(dfclk), .dout(dout),
		.rx0(drx0), .rx1(drx1));
	initial forever #10 mclk = ~mclk;
	// hang guard
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [4:0] a, logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1;
		@(posedge mclk);
		reg_we <= 0;
	endtask
	// data stand in the cycle after the strobe
	task automatic reg_read(logic [4:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_re <= 1;
		@(posedge mclk);
		reg_re <= 0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	function automatic logic [31:0] msk(logic [5:0] w);
		return (w == 32) ? 32'hFFFFFF00 : 32'((64'h1 << w) - 1);
	endfunction
	task automatic finish_test();
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		int lo, p;
		logic tri_s, pf;
		void'($urandom(5));
		repeat (3) @(posedge mclk);
		rst_n <= 1;
		reg_read(A_CTRL, rv);
		chk("ctrl", CTRL_RST, rv);
		reg_read(A_FRAME, rv);
		chk("frame", FRAME_RST, rv);
		reg_read(A_SLOT, rv);
		chk("slot", SLOT_RST, rv);
		wr(5'h1D, 32'hFFFFFFFF);
		reg_read(5'h1D, rv);
		chk("unmapped", 32'h00000000, rv);
		// host master then host slave, every format
		for (int m = 1; m >= 0; m--) begin
			for (int f = 0; f < 4; f++) begin
				fmt = tasp_fmt_t'(2'(f));
				wl = wls[$urandom % 3];
				{htx0, htx1, dtx0, dtx1} = {$urandom, $urandom, $urandom, $urandom};
				tri_s = 1'($urandom);
				wr(A_FRAME, {2'h0, wl, 2'h0, sl, 6'h00, fl});
				wr(A_TX0, htx0);
				wr(A_TX1, htx1);
				dev_mst <= !m;
				wr(A_CTRL, {23'h0, 2'h3, 2'h3, tri_s, fmt, 1'(m), 1'b1});
				if (m && (fmt == FMT_DSPB || fmt == FMT_LJ)) begin
					repeat (200) @(posedge mclk);
					chk("bclk_oe", 0, bclk_oe);
					reg_read(A_STAT, rv);
					chk("running", 0, rv[0]);
				end else begin
					repeat (fl * 8) @(posedge mclk);
					// start from the present level: only real rises count
					{lo, p} = '0;
					pf = fclk_o;
					repeat (fl * 16) begin
						@(posedge mclk);
						lo += !sin_oe;
						p += fclk_o && !pf;
						pf = fclk_o;
					end
					chk("tristate", tri_s, lo > 0);
					chk("bclk_oe", m, bclk_oe);
					chk("fclk_oe", m, fclk_oe);
					if (m)
						chk("frames", 2, p);
					chk("dev rx0", htx0 & msk(wl), drx0);
					chk("dev rx1", htx1 & msk(wl), drx1);
					reg_read(A_RX0, rv);
					chk("rx0", dtx0 & msk(wl), rv);
					reg_read(A_RX1, rv);
					chk("rx1", dtx1 & msk(wl), rv);
					reg_read(A_STAT, rv);
					chk("stat", 3'h7, rv[2:0]);
				end
				wr(A_CTRL, 32'h00000000);
				dev_mst <= 0;
				repeat (fl * 8) @(posedge mclk);
				chk("idle", 0, bclk_oe);
			end
		end
		finish_test();
	end
endmodule // test_tasp_host
